// [logic/vsup_cfg.svh]
// Offsets, reset values and timing figures of the output voltage supervisor.
// Assumes a 40 MHz pclk; included by the package and the test bench.
`ifndef VSUP_CFG_SVH
`define VSUP_CFG_SVH
`define VSUP_CLK_MHZ        40
`define VSUP_OV_DLY_US      100
`define VSUP_HICCUP_MS      10
`define VSUP_SYNC_TMO_US    10
`define VSUP_STRAP_SETTLE   4'h3
`define VSUP_A_OPER         8'h00
`define VSUP_A_VCMD         8'h04
`define VSUP_A_TRIM         8'h08
`define VSUP_A_MHIGH        8'h0C
`define VSUP_A_MLOW         8'h10
`define VSUP_A_VMAX         8'h14
`define VSUP_A_OVLIM        8'h18
`define VSUP_A_UVLIM        8'h1C
`define VSUP_A_PGON         8'h20
`define VSUP_A_PGOFF        8'h24
`define VSUP_A_FCFG         8'h28
`define VSUP_A_FREQ         8'h2C
`define VSUP_A_STAT         8'h30
`define VSUP_A_CLR          8'h34
`define VSUP_A_TGT          8'h38
`define VSUP_PCT_MHIGH      8'h69
`define VSUP_PCT_MLOW       8'h5F
`define VSUP_PCT_VMAX       8'h6E
`define VSUP_PCT_OV         8'h73
`define VSUP_PCT_UV         8'h55
`define VSUP_PCT_PGON       8'h5A
`define VSUP_PCT_PGOFF      8'h55
`define VSUP_PCT_DIV        24'h00_0064
`define VSUP_VMAX_ABS       16'h157C
`define VSUP_VMIN_TBL       16'h0258
`define VSUP_VMAX_TBL       16'h1388
`define VSUP_FREQ_RST       16'h0190
`define VSUP_FCFG_RST       6'h3F
`define VSUP_FCFG_OV        1:0
`define VSUP_FCFG_UV        3:2
`define VSUP_FCFG_OC        5:4
`define VSUP_OPER_MARGIN    1:0
`endif

// [logic/vsup_lut.sv]
// Strap band index to nominal output voltage in millivolts.
// Assumes a four-bit band code; read data is registered.
`timescale 1ns/10ps
module vsup_lut (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  code,
  output logic      [15:0] mv
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv <= 16'h0000;
    end else begin
      unique case (code)
        4'h0: mv <= 16'h0258;
        4'h1: mv <= 16'h02BC;
        4'h2: mv <= 16'h02EE;
        4'h3: mv <= 16'h0320;
        4'h4: mv <= 16'h0352;
        4'h5: mv <= 16'h0384;
        4'h6: mv <= 16'h03B6;
        4'h7: mv <= 16'h03E8;
        4'h8: mv <= 16'h041A;
        4'h9: mv <= 16'h044C;
        4'hA: mv <= 16'h04B0;
        4'hB: mv <= 16'h05DC;
        4'hC: mv <= 16'h0708;
        4'hD: mv <= 16'h09C4;
        4'hE: mv <= 16'h0CE4;
        4'hF: mv <= 16'h1388;
      endcase
    end
  end
endmodule

// [logic/vsup_pkg.sv]
// Types shared by the output voltage supervisor files.
// Assumes vsup_cfg.svh is on the include path.
`include "vsup_cfg.svh"
package vsup_pkg;
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_LOAD  = 3'b010,
    ST_RUN   = 3'b100
  } vsup_state_t;
  typedef enum logic [1:0] {
    RSP_CONT  = 2'b00,
    RSP_DELAY = 2'b01,
    RSP_LATCH = 2'b10,
    RSP_RETRY = 2'b11
  } vsup_resp_t;
  typedef enum logic [1:0] {
    MRG_NONE = 2'b00,
    MRG_LOW  = 2'b01,
    MRG_HIGH = 2'b10
  } vsup_margin_t;
endpackage

// [logic/vsup_top.sv]
// Output voltage setpoint, fault supervision and clock source selection.
// Assumes an APB master on pclk, an ADC word on pclk and asynchronous pins.
`timescale 1ns/10ps
module vsup_top
  import vsup_pkg::*;
#(
  parameter int HICCUP_CYC = `VSUP_HICCUP_MS * `VSUP_CLK_MHZ * 1000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  setpoint_strap_resistor,
  input  wire logic [15:0] vout_meas,
  input  wire logic        ramp_done,
  input  wire logic        cal_done,
  input  wire logic        output_enable,
  input  wire logic        overcurrent_guard,
  input  wire logic        sync_in,
  output logic      [15:0] target_mv,
  output logic             regulator_on,
  output logic             output_valid_flag_o,
  output logic             output_valid_flag_oe,
  output logic             ext_clk_sel,
  output logic      [15:0] osc_freq
);
  localparam int OV_DLY_CYC = `VSUP_OV_DLY_US * `VSUP_CLK_MHZ;
  localparam int SYNC_TMO_CYC = `VSUP_SYNC_TMO_US * `VSUP_CLK_MHZ;

  function automatic logic [15:0] pct(input logic [15:0] v,
                                      input logic [7:0]  p);
    logic [23:0] m;
    m = {8'h00, v} * {16'h0000, p};
    m = m / `VSUP_PCT_DIV;
    return m[15:0];
  endfunction

  vsup_state_t st_r;
  logic [3:0]  settle_r;
  logic [3:0]  strap_s1_r, strap_s2_r;
  logic [15:0] lut_mv, nom_r;
  logic [1:0]  oper_r;
  logic [15:0] vcmd_r, trim_r, mh_r, ml_r, vmax_r, ov_r, uv_r;
  logic [15:0] pgon_r, pgoff_r, freq_r, target_r;
  logic [5:0]  fcfg_r;
  logic [2:0]  seen_r;
  logic        oc_s1_r, oc_s2_r, sy_s1_r, sy_s2_r, sy_d_r;
  logic        en_d_r, ov_latch_r, uv_latch_r, oc_latch_r, hiccup_r;
  logic [31:0] ov_cnt_r, uv_cnt_r, hic_cnt_r;
  logic [15:0] per_cnt_r, per_r, lost_r;
  logic        clk_ok_r, use_ext_r, lost_flag_r, pg_r, load_done_r;
  logic        wr, rd, en_rise, clr_wr;
  logic        ov_hit, uv_hit, oc_hit, ov_off, uv_off, fault_off;
  logic [15:0] base, sum;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign pready  = psel & penable;
  assign en_rise = output_enable & ~en_d_r;
  assign clr_wr  = wr && paddr == `VSUP_A_CLR && pwdata[0];

  vsup_lut u_lut (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (strap_s2_r),
    .mv      (lut_mv)
  );

  // Strap, overcurrent and sync pins pass two flops before use; output_enable is used directly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
      oc_s1_r    <= 1'b0;
      oc_s2_r    <= 1'b0;
      sy_s1_r    <= 1'b0;
      sy_s2_r    <= 1'b0;
      sy_d_r     <= 1'b0;
      en_d_r     <= 1'b0;
    end else begin
      strap_s1_r <= setpoint_strap_resistor;
      strap_s2_r <= strap_s1_r;
      oc_s1_r    <= overcurrent_guard;
      oc_s2_r    <= oc_s1_r;
      sy_s1_r    <= sync_in;
      sy_s2_r    <= sy_s1_r;
      sy_d_r     <= sy_s2_r;
      en_d_r     <= output_enable;
    end
  end

  // The strap is read once after reset; later changes are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= ST_STRAP;
      settle_r <= 4'h0;
      nom_r    <= 16'h0000;
    end else begin
      unique case (st_r)
        ST_STRAP: begin
          settle_r <= settle_r + 4'h1;
          if (settle_r == `VSUP_STRAP_SETTLE) begin
            st_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          st_r <= ST_RUN;
          if (lut_mv < `VSUP_VMIN_TBL) begin
            nom_r <= `VSUP_VMIN_TBL;
          end else if (lut_mv > `VSUP_VMAX_TBL) begin
            nom_r <= `VSUP_VMAX_TBL;
          end else begin
            nom_r <= lut_mv;
          end
        end
        ST_RUN: st_r <= ST_RUN;
      endcase
    end
  end

  // Derived limits load from the nominal level, then software may rewrite.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_r  <= MRG_NONE;
      vcmd_r  <= 16'h0000;
      trim_r  <= 16'h0000;
      mh_r    <= 16'h0000;
      ml_r    <= 16'h0000;
      vmax_r  <= 16'h0000;
      ov_r    <= 16'h0000;
      uv_r    <= 16'h0000;
      pgon_r  <= 16'h0000;
      pgoff_r <= 16'h0000;
      fcfg_r  <= `VSUP_FCFG_RST;
      freq_r  <= `VSUP_FREQ_RST;
    end else if (st_r == ST_LOAD) begin
      vcmd_r  <= (lut_mv < `VSUP_VMIN_TBL) ? `VSUP_VMIN_TBL :
                 (lut_mv > `VSUP_VMAX_TBL) ? `VSUP_VMAX_TBL : lut_mv;
    end else if (st_r == ST_RUN && !load_done_r) begin
      mh_r    <= pct(vcmd_r, `VSUP_PCT_MHIGH);
      ml_r    <= pct(vcmd_r, `VSUP_PCT_MLOW);
      vmax_r  <= (pct(vcmd_r, `VSUP_PCT_VMAX) < `VSUP_VMAX_ABS) ?
                 pct(vcmd_r, `VSUP_PCT_VMAX) : `VSUP_VMAX_ABS;
      ov_r    <= pct(vcmd_r, `VSUP_PCT_OV);
      uv_r    <= pct(vcmd_r, `VSUP_PCT_UV);
      pgon_r  <= pct(vcmd_r, `VSUP_PCT_PGON);
      pgoff_r <= pct(vcmd_r, `VSUP_PCT_PGOFF);
    end else if (wr) begin
      unique case (paddr)
        `VSUP_A_OPER:  oper_r  <= pwdata[`VSUP_OPER_MARGIN];
        `VSUP_A_VCMD:  vcmd_r  <= pwdata[15:0];
        `VSUP_A_TRIM:  trim_r  <= pwdata[15:0];
        `VSUP_A_MHIGH: mh_r    <= pwdata[15:0];
        `VSUP_A_MLOW:  ml_r    <= pwdata[15:0];
        `VSUP_A_VMAX:  vmax_r  <= pwdata[15:0];
        `VSUP_A_OVLIM: ov_r    <= pwdata[15:0];
        `VSUP_A_UVLIM: uv_r    <= pwdata[15:0];
        `VSUP_A_PGON:  pgon_r  <= pwdata[15:0];
        `VSUP_A_PGOFF: pgoff_r <= pwdata[15:0];
        `VSUP_A_FREQ:  freq_r  <= pwdata[15:0];
        `VSUP_A_FCFG: begin
          fcfg_r[3:0] <= pwdata[3:0];
          // Delayed shutdown is not offered for overcurrent.
          fcfg_r[5:4] <= (pwdata[5:4] == RSP_DELAY) ? RSP_RETRY :
                         pwdata[5:4];
        end
        default: ;
      endcase
    end
  end

  // Startup limits are loaded exactly once on the first running cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_done_r <= 1'b0;
    end else if (st_r == ST_RUN) begin
      load_done_r <= 1'b1;
    end
  end

  always_comb begin
    unique case (oper_r)
      MRG_HIGH: base = mh_r;
      MRG_LOW:  base = ml_r;
      default:  base = vcmd_r;
    endcase
    sum = base + trim_r;
  end

  // Clamp acts on the target only; the stored command stays untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_r <= 16'h0000;
    end else if (st_r == ST_RUN) begin
      target_r <= (sum > vmax_r) ? vmax_r : sum;
    end
  end

  assign ov_hit = load_done_r && vout_meas > ov_r;
  // Undervoltage is meaningless while the output is still ramping.
  assign uv_hit = st_r == ST_RUN && ramp_done && vout_meas < uv_r;
  assign oc_hit = st_r == ST_RUN && ramp_done && oc_s2_r;

  // Delay counters restart whenever the fault first appears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cnt_r <= 32'h0000_0000;
      uv_cnt_r <= 32'h0000_0000;
    end else begin
      ov_cnt_r <= ov_hit ? ov_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      uv_cnt_r <= uv_hit ? uv_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_latch_r <= 1'b0;
      uv_latch_r <= 1'b0;
    end else begin
      if (ov_hit && (fcfg_r[`VSUP_FCFG_OV] == RSP_LATCH ||
          (fcfg_r[`VSUP_FCFG_OV] == RSP_DELAY &&
           ov_cnt_r >= 32'(OV_DLY_CYC)))) begin
        ov_latch_r <= 1'b1;
      end else if (clr_wr || en_rise) begin
        ov_latch_r <= 1'b0;
      end
      if (uv_hit && (fcfg_r[`VSUP_FCFG_UV] == RSP_LATCH ||
          (fcfg_r[`VSUP_FCFG_UV] == RSP_DELAY &&
           uv_cnt_r >= 32'(OV_DLY_CYC)))) begin
        uv_latch_r <= 1'b1;
      end else if (clr_wr || en_rise) begin
        uv_latch_r <= 1'b0;
      end
    end
  end

  // Hiccup holds the output off for a fixed interval, then retries.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_latch_r <= 1'b0;
      hiccup_r   <= 1'b0;
      hic_cnt_r  <= 32'h0000_0000;
    end else begin
      if (oc_hit && fcfg_r[`VSUP_FCFG_OC] == RSP_LATCH) begin
        oc_latch_r <= 1'b1;
      end else if (clr_wr || en_rise) begin
        oc_latch_r <= 1'b0;
      end
      if (oc_hit && fcfg_r[`VSUP_FCFG_OC] == RSP_RETRY && !hiccup_r) begin
        hiccup_r  <= 1'b1;
        hic_cnt_r <= 32'h0000_0000;
      end else if (hiccup_r) begin
        hic_cnt_r <= hic_cnt_r + 32'h0000_0001;
        if (hic_cnt_r >= 32'(HICCUP_CYC - 1)) begin
          hiccup_r <= 1'b0;
        end
      end
    end
  end

  assign ov_off = ov_latch_r ||
                  (ov_hit && fcfg_r[`VSUP_FCFG_OV] == RSP_RETRY);
  assign uv_off = uv_latch_r ||
                  (uv_hit && fcfg_r[`VSUP_FCFG_UV] == RSP_RETRY);
  assign fault_off = ov_off || uv_off || oc_latch_r || hiccup_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_on <= 1'b0;
    end else begin
      regulator_on <= st_r == ST_RUN && load_done_r && output_enable &&
                      !fault_off;
    end
  end

  // Power-good never rises before calibration, even at full voltage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_r <= 1'b0;
    end else if (!regulator_on || fault_off || ov_hit || uv_hit ||
                 oc_hit || !ramp_done) begin
      pg_r <= 1'b0;
    end else if (vout_meas < pgoff_r) begin
      pg_r <= 1'b0;
    end else if (vout_meas > pgon_r && cal_done) begin
      pg_r <= 1'b1;
    end
  end
  assign output_valid_flag_o  = 1'b0;
  assign output_valid_flag_oe = ~pg_r;

  // Sync period is measured in pclk cycles; timeout marks a missing clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 16'h0000;
      per_r     <= 16'h0000;
      clk_ok_r  <= 1'b0;
    end else if (sy_s2_r && !sy_d_r) begin
      per_cnt_r <= 16'h0000;
      per_r     <= per_cnt_r;
      clk_ok_r  <= 1'b1;
    end else if (per_cnt_r >= 16'(SYNC_TMO_CYC)) begin
      clk_ok_r  <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_ext_r   <= 1'b0;
      lost_flag_r <= 1'b0;
      lost_r      <= 16'h0000;
    end else if (st_r == ST_LOAD || en_rise) begin
      use_ext_r   <= clk_ok_r;
      lost_flag_r <= 1'b0;
    end else if (use_ext_r && !clk_ok_r) begin
      use_ext_r   <= 1'b0;
      lost_flag_r <= 1'b1;
      lost_r      <= per_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_freq <= `VSUP_FREQ_RST;
    end else begin
      osc_freq <= lost_flag_r ? lost_r : freq_r;
    end
  end

  // Sticky fault record; a new fault wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 3'h0;
    end else begin
      seen_r <= (clr_wr ? 3'h0 : seen_r) | {oc_hit, uv_hit, ov_hit};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= paddr > `VSUP_A_TGT || paddr[1:0] != 2'h0;
      if (rd) begin
        unique case (paddr)
          `VSUP_A_OPER:  prdata <= {30'h0000_0000, oper_r};
          `VSUP_A_VCMD:  prdata <= {16'h0000, vcmd_r};
          `VSUP_A_TRIM:  prdata <= {16'h0000, trim_r};
          `VSUP_A_MHIGH: prdata <= {16'h0000, mh_r};
          `VSUP_A_MLOW:  prdata <= {16'h0000, ml_r};
          `VSUP_A_VMAX:  prdata <= {16'h0000, vmax_r};
          `VSUP_A_OVLIM: prdata <= {16'h0000, ov_r};
          `VSUP_A_UVLIM: prdata <= {16'h0000, uv_r};
          `VSUP_A_PGON:  prdata <= {16'h0000, pgon_r};
          `VSUP_A_PGOFF: prdata <= {16'h0000, pgoff_r};
          `VSUP_A_FCFG:  prdata <= {26'h000_0000, fcfg_r};
          `VSUP_A_FREQ:  prdata <= {16'h0000, freq_r};
          `VSUP_A_STAT:  prdata <= {nom_r, 4'h0, use_ext_r, clk_ok_r,
                                    pg_r, hiccup_r, oc_latch_r, uv_latch_r,
                                    ov_latch_r, 2'h0, seen_r};
          `VSUP_A_TGT:   prdata <= {16'h0000, target_r};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign target_mv   = target_r;
  assign ext_clk_sel = use_ext_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strap_hold_a: assert property (st_r == ST_RUN && $past(st_r) == ST_RUN
    |-> $stable(nom_r)) else $error("nominal moved after startup");
  clamp_tgt_a: assert property (st_r == ST_RUN |=> target_r <= $past(vmax_r))
    else $error("target above clamp");
  margin_sel_a: assert property (st_r == ST_RUN && oper_r == MRG_HIGH &&
    trim_r == 16'h0000 && mh_r <= vmax_r |=> target_r == $past(mh_r))
    else $error("margin high not used");
  pg_fault_a: assert property (fault_off |=> !pg_r)
    else $error("power good high in fault");
  pg_cal_a: assert property ($rose(pg_r) |-> $past(cal_done))
    else $error("power good before calibration");
  ov_retry_a: assert property (ov_hit && fcfg_r[`VSUP_FCFG_OV] == RSP_RETRY
    |=> !regulator_on) else $error("overvoltage did not stop");
  oc_gate_a: assert property ($rose(hiccup_r) |-> $past(ramp_done))
    else $error("overcurrent before ramp done");
  ext_lost_a: assert property (use_ext_r && !clk_ok_r && !en_rise &&
    st_r == ST_RUN |=> !use_ext_r ##1 osc_freq == $past(per_r, 2))
    else $error("no fallback on lost sync");
endmodule

// [verif/vout_supervisor_fault_response_test.sv]
// Self-checking bench for the output voltage supervisor over APB.
// Assumes vsup_cfg.svh on the include path and the load model.
`timescale 1ns/10ps
`include "vsup_cfg.svh"
module vout_supervisor_fault_response_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, ramp_done, cal_done, sync_in;
  logic [3:0]  strap = 4'h7;
  logic [15:0] vout_meas, target_mv, osc_freq;
  logic [15:0] ext_mv = 16'h0000;
  logic        oen = 1'b0;
  logic        oc = 1'b0;
  logic        sync_en = 1'b0;
  logic        regulator_on, pg_o, pg_oe, ext_clk_sel;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0]  dflt_a [10] = '{`VSUP_A_MHIGH, `VSUP_A_MLOW, `VSUP_A_VMAX,
    `VSUP_A_OVLIM, `VSUP_A_UVLIM, `VSUP_A_PGON, `VSUP_A_PGOFF,
    `VSUP_A_FCFG, `VSUP_A_FREQ, `VSUP_A_VCMD};
  logic [31:0] dflt_v [10] = '{32'h0000_041A, 32'h0000_03B6, 32'h0000_044C,
    32'h0000_047E, 32'h0000_0352, 32'h0000_0384, 32'h0000_0352,
    32'h0000_003F, 32'h0000_0190, 32'h0000_03E8};
  logic [15:0] mrg_v [3] = '{16'h03E8, 16'h03B6, 16'h041A};

  vsup_top #(.HICCUP_CYC(50)) vsup_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setpoint_strap_resistor(strap), .vout_meas(vout_meas),
    .ramp_done(ramp_done), .cal_done(cal_done), .output_enable(oen),
    .overcurrent_guard(oc), .sync_in(sync_in), .target_mv(target_mv),
    .regulator_on(regulator_on), .output_valid_flag_o(pg_o),
    .output_valid_flag_oe(pg_oe), .ext_clk_sel(ext_clk_sel),
    .osc_freq(osc_freq));
  vsup_load_model vsup_load_model_inst (.pclk(pclk), .presetn(presetn),
    .regulator_on(regulator_on), .target_mv(target_mv), .ext_mv(ext_mv),
    .sync_en(sync_en), .vout_meas(vout_meas), .ramp_done(ramp_done),
    .cal_done(cal_done), .sync_in(sync_in));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    repeat (3) @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r & m, x);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    cyc(60000);
    n_fail++;
    wrap_up();
  end

  initial begin
    int          i;
    logic [31:0] r;
    logic        e;
    cyc(16);
    presetn <= 1'b1;
    cyc(20);
    for (i = 0; i < 10; i++) rd(dflt_a[i], dflt_v[i]);
    rd(`VSUP_A_FCFG, 32'h0000_003F);
    rd(`VSUP_A_STAT, 32'h03E8_0000, 32'hFFFF_0000);
    strap <= 4'hF;
    cyc(10);
    rd(`VSUP_A_STAT, 32'h03E8_0000, 32'hFFFF_0000);
    chk(target_mv, 16'h03E8);
    apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    chk(pg_oe, 1'b1);
    chk(pg_o, 1'b0);
    chk(ext_clk_sel, 1'b0);
    wr(`VSUP_A_VCMD, 32'h0000_04B0);
    chk(target_mv, 16'h044C);
    rd(`VSUP_A_VCMD, 32'h0000_04B0);
    wr(`VSUP_A_VCMD, 32'h0000_041A);
    wr(`VSUP_A_TRIM, 32'h0000_0014);
    chk(target_mv, 16'h042E);
    wr(`VSUP_A_TRIM, 32'h0000_FFEC);
    chk(target_mv, 16'h0406);
    wr(`VSUP_A_TRIM, 32'h0000_0000);
    wr(`VSUP_A_VCMD, 32'h0000_03E8);
    for (i = 0; i < 3; i++) begin
      wr(`VSUP_A_OPER, i);
      chk(target_mv, mrg_v[i]);
    end
    wr(`VSUP_A_MHIGH, 32'h0000_0438);
    chk(target_mv, 16'h0438);
    wr(`VSUP_A_OPER, 32'h0000_0000);
    wr(`VSUP_A_FREQ, 32'h0000_07D0);
    rd(`VSUP_A_FREQ, 32'h0000_07D0);
    chk(osc_freq, 16'h07D0);
    sync_en <= 1'b1;
    cyc(100);
    oen <= 1'b1;
    cyc(2);
    chk(pg_oe, 1'b1);
    for (i = 0; i < 300 && pg_oe !== 1'b0; i++) @(posedge pclk);
    chk(pg_oe, 1'b0);
    chk(ext_clk_sel, 1'b1);
    wr(`VSUP_A_PGON, 32'h0000_03DE);
    wr(`VSUP_A_PGOFF, 32'h0000_03D4);
    ext_mv <= 16'hFFE2;
    cyc(10);
    chk(pg_oe, 1'b1);
    ext_mv <= 16'h0000;
    cyc(10);
    chk(pg_oe, 1'b0);
    sync_en <= 1'b0;
    cyc(500);
    chk(ext_clk_sel, 1'b0);
    chk(osc_freq >= 16'd19 && osc_freq <= 16'd21, 1'b1);
    for (i = 0; i < 4; i++) begin
      wr(`VSUP_A_FCFG, {26'h0, 4'hF, 2'(i)});
      // The source alone lies above the limit, so the fault outlasts a trip.
      ext_mv <= 16'h04B0;
      cyc(4100);
      chk(regulator_on, i == 0);
      chk(pg_oe, 1'b1);
      ext_mv <= 16'h0000;
      cyc(50);
      chk(regulator_on, i == 0 || i == 3);
      wr(`VSUP_A_CLR, 32'h0000_0001);
      cyc(50);
      chk(regulator_on, 1'b1);
    end
    wr(`VSUP_A_FCFG, 32'h0000_003B);
    ext_mv <= 16'hFED4;
    cyc(10);
    ext_mv <= 16'h0000;
    cyc(50);
    chk(regulator_on, 1'b0);
    wr(`VSUP_A_CLR, 32'h0000_0001);
    cyc(50);
    chk(regulator_on, 1'b1);
    wr(`VSUP_A_FCFG, 32'h0000_003F);
    oen <= 1'b0;
    oc <= 1'b1;
    cyc(10);
    oen <= 1'b1;
    cyc(5);
    chk(regulator_on, 1'b1);
    cyc(60);
    chk(regulator_on, 1'b0);
    oc <= 1'b0;
    cyc(100);
    chk(regulator_on, 1'b1);
    wr(`VSUP_A_FCFG, 32'h0000_001F);
    rd(`VSUP_A_FCFG, 32'h0000_003F);
    wr(`VSUP_A_FCFG, 32'h0000_002F);
    oc <= 1'b1;
    cyc(10);
    oc <= 1'b0;
    cyc(100);
    chk(regulator_on, 1'b0);
    wr(`VSUP_A_CLR, 32'h0000_0001);
    cyc(50);
    chk(regulator_on, 1'b1);
    // A fresh power-up must pick up the strap that changed earlier.
    presetn <= 1'b0;
    cyc(2);
    chk(pg_oe, 1'b1);
    presetn <= 1'b1;
    cyc(20);
    chk(pg_oe, 1'b1);
    chk(osc_freq, 16'h0190);
    rd(`VSUP_A_STAT, 32'h1388_0000, 32'hFFFF_0000);
    rd(`VSUP_A_VMAX, 32'h0000_157C);
    wrap_up();
  end
endmodule

// [verif/vsup_load_model.sv]
// Load, output sensing and sync clock source facing the supervisor.
// Assumes the pclk domain; ext_mv is an outside source on the output.
`timescale 1ns/10ps
module vsup_load_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        regulator_on,
  input  wire logic [15:0] target_mv,
  input  wire logic [15:0] ext_mv,
  input  wire logic        sync_en,
  output logic      [15:0] vout_meas,
  output logic             ramp_done,
  output logic             cal_done,
  output logic             sync_in
);
  logic [15:0] lvl_r;
  logic [3:0]  cal_r;
  logic [4:0]  sdiv_r;
  // The output slews 50 mV a cycle, so a ramp is seen and not a step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lvl_r <= 16'h0000;
    else if (!regulator_on) lvl_r <= 16'h0000;
    else if (lvl_r + 16'h0032 < target_mv) lvl_r <= lvl_r + 16'h0032;
    else lvl_r <= target_mv;
  end
  assign vout_meas = lvl_r + ext_mv;
  assign ramp_done = regulator_on && (lvl_r == target_mv);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cal_r <= 4'h0;
    else if (!ramp_done) cal_r <= 4'h0;
    else if (cal_r != 4'h8) cal_r <= cal_r + 4'h1;
  end
  assign cal_done = (cal_r == 4'h8);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sdiv_r <= 5'h00;
    else if (!sync_en || sdiv_r == 5'h13) sdiv_r <= 5'h00;
    else sdiv_r <= sdiv_r + 5'h01;
  end
  // Sync stands still low while the source is off.
  assign sync_in = sync_en && (sdiv_r < 5'h0A);
endmodule
